// file: core/fsc_slot_failsafe.sv
`timescale 1ns/100ps
// Overview of operation
// R1: refuse cyclic connection while configured layout differs from fitted.
// R2: diagnostics module allowed only in slot 1, four input bytes.
// R3: valve module always configured, slot 1 or slot 2 after diagnostics.
// R4: expansion modules follow valve slot, eight at most.
// R5: new layout adopted only after logic supply off and on.
// R6: logic supply drop raises event when enabled, enabled by default.
// R7: main load supply drop raises event when enabled, default off.
// R8: first extra load supply drop raises event when enabled.
// R9: further extra supplies share one event enable, default off.
// R10: on bus fault each valve takes its own action, default off.
// R11: logic supply under-voltage shown as a bit of diagnostics byte.
// R12: one shared diagnostics bit for all further extra supplies.
// R13: hold action keeps last controller value until cyclic data resumes.
module fsc_slot_failsafe #(
   parameter int N_FURTHER = 8,
   parameter int VALVES = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // supplies
   input wire logic logic_sensor_supply_on,
   input wire logic logic_sensor_supply_low,
   input wire logic main_load_supply_low,
   input wire logic first_extra_load_supply_low,
   input wire logic [N_FURTHER-1:0] further_extra_load_supplies_low,
   // fitted modules and link
   input wire logic [fsc_pkg::CODE_W*fsc_pkg::EXP_MAX-1:0] fitted_modules,
   input wire logic link_up,
   input wire logic bus_fault,
   // outputs
   output logic cyclic_connected,
   output logic [VALVES-1:0] valve_out,
   output logic [7:0] general_diag,
   output logic irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      fsc_pkg::fsc_state_t st;
      logic [3:0] evt_en;
      logic [fsc_pkg::NUM_EVT-1:0] status;
      logic [fsc_pkg::NUM_EVT-1:0] mask;
      logic [fsc_pkg::CFG_W-1:0] cfg_pend;
      logic [fsc_pkg::CFG_W-1:0] cfg_act;
      logic [2*VALVES-1:0] fail_act;
      logic [VALVES-1:0] valve_cmd;
      logic [VALVES-1:0] valve_out;
      logic [3:0] low_q;
      logic supply_on_q;
      logic [31:0] rdata;
   } fsc_regs_t;

   fsc_regs_t r;
   fsc_regs_t next_r;
   logic match;
   logic diag_present;
   logic valves32;
   logic [3:0] low_now;
   logic [VALVES-1:0] fault_val;
   logic [VALVES-1:0] vmask;

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   function automatic logic hit(
      input logic strobe,
      input logic [fsc_pkg::ADDR_W-1:0] addr,
      input logic [7:0] ofs
   );
      return strobe && addr == ofs;
   endfunction

   // ----------------------------------------
   // live status word
   // ----------------------------------------
   function automatic logic [31:0] live_word(
      input fsc_pkg::fsc_state_t st,
      input logic mis,
      input logic diag,
      input logic wide,
      input logic [3:0] lows
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      w[fsc_pkg::LIVE_CONN] = st == fsc_pkg::FSC_RUN;
      w[fsc_pkg::LIVE_MISMATCH] = mis;
      w[fsc_pkg::LIVE_DIAG] = diag;
      w[fsc_pkg::LIVE_V32] = wide;
      w[fsc_pkg::LIVE_FAULT] = st == fsc_pkg::FSC_FAULT;
      w[fsc_pkg::LIVE_DIAG_BYTE +: 4] = lows;
      return w;
   endfunction

   // ----------------------------------------
   // layout comparison
   // ----------------------------------------
   fsc_layout_check u_check (
      .cfg(r.cfg_act),
      .fitted(fitted_modules),
      .match(match),
      .diag_present(diag_present),
      .valves32(valves32)
   );

   // R12: further supplies share one bit
   assign low_now = {|further_extra_load_supplies_low,
      first_extra_load_supply_low, main_load_supply_low,
      logic_sensor_supply_low};

   // ----------------------------------------
   // per-valve fault value
   // ----------------------------------------
   generate
      for (genvar g = 0; g < VALVES; g++) begin : g_fail
         always_comb begin
            // R10: drive low, high or hold
            case (r.fail_act[2*g +: 2])
               fsc_pkg::FAULT_DRIVE_HIGH: fault_val[g] = 1'b1;
               // R13: last controller value
               fsc_pkg::FAULT_HOLD: fault_val[g] = r.valve_cmd[g];
               default: fault_val[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   // ----------------------------------------
   // valve width mask
   // ----------------------------------------
   generate
      for (genvar v = 0; v < VALVES; v++) begin : g_vmask
         // R10: sixteen or thirty-two valves
         assign vmask[v] = valves32 || v < fsc_pkg::VALVE_NARROW;
      end
   endgenerate

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [fsc_pkg::NUM_EVT-1:0] set_evt;
      next_r = r;
      set_evt = '0;

      // ----------------------------------------
      // supply events
      // ----------------------------------------
      // R6: logic supply event
      // R7: main supply event
      // R8: first extra supply event
      // R9: further extra supplies event
      set_evt[3:0] = low_now & ~r.low_q & r.evt_en;
      next_r.low_q = low_now;

      // ----------------------------------------
      // layout adoption and link state
      // ----------------------------------------
      // R5: adopt layout on logic supply power-up
      next_r.supply_on_q = logic_sensor_supply_on;
      if (logic_sensor_supply_on && !r.supply_on_q) begin
         next_r.cfg_act = r.cfg_pend;
         next_r.st = fsc_pkg::FSC_IDLE;
      end else begin
         case (r.st)
            fsc_pkg::FSC_IDLE: begin
               // R1: refuse on mismatch
               if (link_up && match) begin
                  next_r.st = fsc_pkg::FSC_RUN;
               end else if (link_up) begin
                  next_r.st = fsc_pkg::FSC_REFUSE;
                  set_evt[fsc_pkg::EVT_LAYOUT] = 1'b1;
               end
            end
            fsc_pkg::FSC_RUN: begin
               if (bus_fault || !link_up) begin
                  next_r.st = fsc_pkg::FSC_FAULT;
               end
            end
            fsc_pkg::FSC_FAULT: begin
               // R13: resume on fresh cyclic data
               if (hit(reg_wr, reg_addr, fsc_pkg::OFS_VALVE) && link_up &&
                   !bus_fault && match) begin
                  next_r.st = fsc_pkg::FSC_RUN;
               end
            end
            fsc_pkg::FSC_REFUSE: begin
               if (!link_up) begin
                  next_r.st = fsc_pkg::FSC_IDLE;
               end
            end
            default: next_r.st = fsc_pkg::FSC_IDLE;
         endcase
      end

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (reg_wr) begin
         case (reg_addr)
            fsc_pkg::OFS_EVT_EN: next_r.evt_en = reg_wdata[3:0];
            fsc_pkg::OFS_MASK:
               next_r.mask = reg_wdata[fsc_pkg::NUM_EVT-1:0];
            fsc_pkg::OFS_CFG_LO: next_r.cfg_pend[31:0] = reg_wdata;
            fsc_pkg::OFS_CFG_HI:
               next_r.cfg_pend[fsc_pkg::CFG_W-1:32] =
                  reg_wdata[fsc_pkg::CFG_W-33:0];
            fsc_pkg::OFS_FAIL_LO: next_r.fail_act[31:0] = reg_wdata;
            fsc_pkg::OFS_FAIL_HI:
               next_r.fail_act[2*VALVES-1:32] = reg_wdata[2*VALVES-33:0];
            fsc_pkg::OFS_VALVE: begin
               if (r.st == fsc_pkg::FSC_RUN ||
                   next_r.st == fsc_pkg::FSC_RUN) begin
                  next_r.valve_cmd = reg_wdata[VALVES-1:0];
               end
            end
            default: ;
         endcase
      end

      // ----------------------------------------
      // register reads
      // ----------------------------------------
      next_r.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            fsc_pkg::OFS_EVT_EN: next_r.rdata[3:0] = r.evt_en;
            fsc_pkg::OFS_STATUS:
               next_r.rdata[fsc_pkg::NUM_EVT-1:0] = r.status;
            fsc_pkg::OFS_MASK: next_r.rdata[fsc_pkg::NUM_EVT-1:0] = r.mask;
            fsc_pkg::OFS_LIVE:
               next_r.rdata = live_word(r.st, !match, diag_present,
                  valves32, r.low_q);
            fsc_pkg::OFS_CFG_LO: next_r.rdata = r.cfg_pend[31:0];
            fsc_pkg::OFS_CFG_HI:
               next_r.rdata[fsc_pkg::CFG_W-33:0] =
                  r.cfg_pend[fsc_pkg::CFG_W-1:32];
            fsc_pkg::OFS_FAIL_LO: next_r.rdata = r.fail_act[31:0];
            fsc_pkg::OFS_FAIL_HI:
               next_r.rdata[2*VALVES-33:0] = r.fail_act[2*VALVES-1:32];
            fsc_pkg::OFS_VALVE: next_r.rdata[VALVES-1:0] = r.valve_cmd;
            default: ;
         endcase
      end

      // ----------------------------------------
      // sticky status, read clears, set wins
      // ----------------------------------------
      next_r.status = r.status | set_evt;
      if (hit(reg_rd, reg_addr, fsc_pkg::OFS_STATUS)) begin
         next_r.status = set_evt;
      end

      // ----------------------------------------
      // valve drive
      // ----------------------------------------
      case (next_r.st)
         fsc_pkg::FSC_RUN: next_r.valve_out = next_r.valve_cmd & vmask;
         // R10: fault action per valve
         fsc_pkg::FSC_FAULT: next_r.valve_out = fault_val & vmask;
         default: next_r.valve_out = '0;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.st <= fsc_pkg::FSC_IDLE;
         // R6: logic supply event on by default
         r.evt_en <= fsc_pkg::EVT_EN_RST;
         r.mask <= fsc_pkg::MASK_RST;
         // R10: default drive low
         r.fail_act <= fsc_pkg::FAIL_RST[2*VALVES-1:0];
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata = r.rdata;
   assign valve_out = r.valve_out;
   // R1: connected only with matching layout
   assign cyclic_connected = r.st == fsc_pkg::FSC_RUN;
   // R11: logic supply bit in diagnostics byte
   assign general_diag = {4'h0, r.low_q};

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   // R6: unmasked sticky events raise irq
   assign irq = |(r.status & r.mask);
endmodule

// file: common/fsc_pkg.sv
package fsc_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_EVT_EN = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_LIVE = 8'h0C;
   localparam logic [7:0] OFS_CFG_LO = 8'h10;
   localparam logic [7:0] OFS_CFG_HI = 8'h14;
   localparam logic [7:0] OFS_FAIL_LO = 8'h18;
   localparam logic [7:0] OFS_FAIL_HI = 8'h1C;
   localparam logic [7:0] OFS_VALVE = 8'h20;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int EVT_LOGIC = 0;
   localparam int EVT_MAIN = 1;
   localparam int EVT_FIRST = 2;
   localparam int EVT_FURTHER = 3;
   localparam int EVT_LAYOUT = 4;
   localparam int NUM_EVT = 5;
   localparam int LIVE_CONN = 0;
   localparam int LIVE_MISMATCH = 1;
   localparam int LIVE_DIAG = 2;
   localparam int LIVE_V32 = 3;
   localparam int LIVE_FAULT = 4;
   localparam int LIVE_DIAG_BYTE = 8;
   localparam logic [3:0] EVT_EN_RST = 4'h1;
   localparam logic [4:0] MASK_RST = 5'h00;
   localparam logic [63:0] FAIL_RST = 64'h0000_0000_0000_0000;

   // ----------------------------------------
   // slot layout and module codes
   // ----------------------------------------
   localparam int CODE_W = 4;
   localparam int NUM_SLOTS = 10;
   localparam int EXP_MAX = 8;
   localparam int CFG_W = CODE_W * NUM_SLOTS;
   localparam logic [3:0] MOD_NONE = 4'h0;
   localparam logic [3:0] MOD_DIN = 4'h1;
   localparam logic [3:0] MOD_DOUT = 4'h2;
   localparam logic [3:0] MOD_DOUT_SUP = 4'h3;
   localparam logic [3:0] MOD_AIN = 4'h4;
   localparam logic [3:0] MOD_DIAG1 = 4'h5;
   localparam logic [3:0] MOD_DIAG2 = 4'h6;
   localparam logic [3:0] MOD_VALVE16 = 4'h7;
   localparam logic [3:0] MOD_VALVE32 = 4'h8;
   localparam int VALVE_NARROW = 16;

   // ----------------------------------------
   // fault actions and states
   // ----------------------------------------
   localparam logic [1:0] FAULT_DRIVE_LOW = 2'h0;
   localparam logic [1:0] FAULT_DRIVE_HIGH = 2'h1;
   localparam logic [1:0] FAULT_HOLD = 2'h2;

   typedef enum logic [1:0] {
      FSC_IDLE = 2'b00,
      FSC_RUN = 2'b01,
      FSC_FAULT = 2'b11,
      FSC_REFUSE = 2'b10
   } fsc_state_t;
endpackage

// file: core/fsc_layout_check.sv
`timescale 1ns/100ps
module fsc_layout_check (
   // configured and fitted layouts
   input wire logic [fsc_pkg::CFG_W-1:0] cfg,
   input wire logic [fsc_pkg::CODE_W*fsc_pkg::EXP_MAX-1:0] fitted,
   // results
   output logic match,
   output logic diag_present,
   output logic valves32
);
   // ----------------------------------------
   // slot decode
   // ----------------------------------------
   function automatic logic [3:0] slot_code(
      input logic [fsc_pkg::CFG_W-1:0] c,
      input int idx
   );
      return c[idx*fsc_pkg::CODE_W +: fsc_pkg::CODE_W];
   endfunction

   function automatic logic is_exp(input logic [3:0] c);
      return c == fsc_pkg::MOD_NONE || c == fsc_pkg::MOD_DIN ||
         c == fsc_pkg::MOD_DOUT || c == fsc_pkg::MOD_DOUT_SUP ||
         c == fsc_pkg::MOD_AIN;
   endfunction

   always_comb begin
      logic [3:0] valve;
      logic [3:0] fit;
      logic ok;
      int vidx;
      valve = 4'h0;
      fit = 4'h0;
      ok = 1'b1;
      vidx = 0;
      // R2: diagnostics only in slot 1
      diag_present = slot_code(cfg, 0) == fsc_pkg::MOD_DIAG1 ||
         slot_code(cfg, 0) == fsc_pkg::MOD_DIAG2;
      vidx = diag_present ? 1 : 0;
      // R3: valve module is mandatory
      valve = slot_code(cfg, vidx);
      valves32 = valve == fsc_pkg::MOD_VALVE32;
      if (valve != fsc_pkg::MOD_VALVE16 && !valves32) begin
         ok = 1'b0;
      end
      // R4: expansion list, at most eight
      for (int i = 0; i < fsc_pkg::EXP_MAX; i++) begin
         fit = fitted[i*fsc_pkg::CODE_W +: fsc_pkg::CODE_W];
         if (slot_code(cfg, vidx + 1 + i) != fit || !is_exp(fit)) begin
            ok = 1'b0;
         end
      end
      if (!diag_present &&
          slot_code(cfg, fsc_pkg::NUM_SLOTS - 1) != fsc_pkg::MOD_NONE) begin
         ok = 1'b0;
      end
      match = ok;
   end
endmodule

// file: tb/fsc_ctrl_model.sv
`timescale 1ns/100ps
// ----
// controller side: layout it configures, link and fault
// ----
module fsc_ctrl_model (
   // bench requests
   input wire logic use_diag,
   input wire logic wide,
   input wire logic [31:0] fitted,
   input wire logic want_link,
   input wire logic want_fault,
   // towards the unit
   output logic [39:0] layout,
   output logic link_up,
   output logic bus_fault
);
   logic [3:0] vcode;
   assign vcode = wide ? fsc_pkg::MOD_VALVE32 : fsc_pkg::MOD_VALVE16;
   assign layout = use_diag ? {fitted, vcode, fsc_pkg::MOD_DIAG1} :
      {4'h0, fitted, vcode};
   assign link_up = want_link;
   assign bus_fault = want_fault;
endmodule

// file: tb/fsc_slot_failsafe_props.sv
`timescale 1ns/100ps
// ----
// port checks
// ----
module fsc_slot_failsafe_props #(
   parameter int N_FURTHER = 8,
   parameter int VALVES = 32
) (
   // clock, reset, bus
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_wr,
   // supplies and link
   input wire logic logic_sensor_supply_on,
   input wire logic logic_sensor_supply_low,
   input wire logic main_load_supply_low,
   input wire logic first_extra_load_supply_low,
   input wire logic [N_FURTHER-1:0] further_extra_load_supplies_low,
   input wire logic link_up,
   input wire logic bus_fault,
   // outputs
   input wire logic cyclic_connected,
   input wire logic [VALVES-1:0] valve_out,
   input wire logic [7:0] general_diag,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   property p_conn_link;
      $rose(cyclic_connected) |-> $past(link_up);
   endproperty
   a_conn_link: assert property (p_conn_link)
      else $error("connected without link");
   property p_link_loss;
      cyclic_connected && !link_up |=> !cyclic_connected;
   endproperty
   a_link_loss: assert property (p_link_loss)
      else $error("still connected after link loss");
   property p_fault_drop;
      cyclic_connected && bus_fault |=> !cyclic_connected;
   endproperty
   a_fault_drop: assert property (p_fault_drop)
      else $error("still connected after bus fault");
   property p_power_up;
      $rose(logic_sensor_supply_on) |=> !cyclic_connected;
   endproperty
   a_power_up: assert property (p_power_up)
      else $error("connected across power up");
   property p_diag_logic;
      !$past(rst) |-> general_diag[0] == $past(logic_sensor_supply_low);
   endproperty
   a_diag_logic: assert property (p_diag_logic)
      else $error("logic supply diag bit wrong");
   property p_diag_loads;
      !$past(rst) |-> general_diag[2:1] ==
         $past({first_extra_load_supply_low, main_load_supply_low});
   endproperty
   a_diag_loads: assert property (p_diag_loads)
      else $error("load supply diag bits wrong");
   property p_diag_further;
      !$past(rst) |-> general_diag[7:3] ==
         {4'h0, |$past(further_extra_load_supplies_low)};
   endproperty
   a_diag_further: assert property (p_diag_further)
      else $error("further supply diag bit wrong");
   property p_run_hold;
      (cyclic_connected && !reg_wr) [*3] |-> $stable(valve_out);
   endproperty
   a_run_hold: assert property (p_run_hold)
      else $error("valve drive moved without command");
   property p_reset_safe;
      $past(rst) |-> valve_out == '0 && !cyclic_connected && !irq;
   endproperty
   a_reset_safe: assert property (p_reset_safe)
      else $error("outputs not safe after reset");
   c_fault: cover property (cyclic_connected && bus_fault);
   c_irq: cover property ($rose(irq));
   c_power: cover property ($rose(logic_sensor_supply_on));
endmodule

// file: tb/fsc_slot_failsafe_bench.sv
`timescale 1ns/100ps
// ----
// bench
// ----
module fsc_slot_failsafe_bench;
   logic sys_clk, rst, reg_wr, reg_rd, use_diag, wide;
   logic [7:0] reg_addr, general_diag, further_extra_load_supplies_low;
   logic [31:0] reg_wdata, reg_rdata, valve_out, fitted_modules, cmd, exp_v;
   logic logic_sensor_supply_on, logic_sensor_supply_low;
   logic main_load_supply_low, first_extra_load_supply_low;
   logic want_link, want_fault, link_up, bus_fault, cyclic_connected, irq;
   logic [39:0] layout;
   logic [63:0] fail;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   fsc_slot_failsafe dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .logic_sensor_supply_on, .logic_sensor_supply_low,
      .main_load_supply_low, .first_extra_load_supply_low,
      .further_extra_load_supplies_low, .fitted_modules, .link_up,
      .bus_fault, .cyclic_connected, .valve_out, .general_diag, .irq);
   fsc_ctrl_model ctrl (.use_diag, .wide, .fitted(fitted_modules),
      .want_link, .want_fault, .layout, .link_up, .bus_fault);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
      @(posedge sys_clk);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {logic_sensor_supply_low, main_load_supply_low} = 2'h0;
      first_extra_load_supply_low = 1'b0;
      further_extra_load_supplies_low = 8'h00;
      logic_sensor_supply_on = 1'b1;
      fitted_modules = 32'h1234_4321;
      {use_diag, wide, want_link, want_fault} = 4'hC;
      step(3);
      rst <= 1'b0;
      rd(fsc_pkg::OFS_EVT_EN, 32'h0000_0001);
      rd(fsc_pkg::OFS_FAIL_HI, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      $display("test defaults done");
      wr(fsc_pkg::OFS_CFG_LO, layout[31:0]);
      wr(fsc_pkg::OFS_CFG_HI, {24'h00_0000, layout[39:32]});
      want_link <= 1'b1;
      step(4);
      #1 chk({31'h0, cyclic_connected}, 32'h0000_0000);
      rd(fsc_pkg::OFS_STATUS, 32'h0000_0010);
      want_link <= 1'b0;
      step(2);
      logic_sensor_supply_on <= 1'b0;
      step(2);
      logic_sensor_supply_on <= 1'b1;
      step(2);
      want_link <= 1'b1;
      step(4);
      #1 chk({31'h0, cyclic_connected}, 32'h0000_0001);
      rd(fsc_pkg::OFS_LIVE, 32'h0000_000D);
      $display("test layout done");
      fail = 64'hE4E4_E4E4_E4E4_E4E4;
      cmd = 32'hA5A5_0FF0;
      wr(fsc_pkg::OFS_FAIL_LO, fail[31:0]);
      wr(fsc_pkg::OFS_FAIL_HI, fail[63:32]);
      wr(fsc_pkg::OFS_VALVE, cmd);
      step(2);
      #1 chk(valve_out, cmd);
      want_fault <= 1'b1;
      step(3);
      for (int i = 0; i < 32; i++)
         exp_v[i] = fail[2*i+:2] == 2'h1 ? 1'b1 :
            (fail[2*i+:2] == 2'h2 ? cmd[i] : 1'b0);
      #1 chk(valve_out, exp_v);
      wr(fsc_pkg::OFS_VALVE, ~cmd);
      step(2);
      #1 chk(valve_out, exp_v);
      rd(fsc_pkg::OFS_LIVE, 32'h0000_001C);
      want_fault <= 1'b0;
      wr(fsc_pkg::OFS_VALVE, ~cmd);
      step(2);
      #1 chk(valve_out, ~cmd);
      $display("test failsafe done");
      wr(fsc_pkg::OFS_EVT_EN, 32'h0000_000F);
      wr(fsc_pkg::OFS_MASK, 32'h0000_000F);
      for (int k = 0; k < 4; k++) begin
         {further_extra_load_supplies_low[5], first_extra_load_supply_low,
            main_load_supply_low, logic_sensor_supply_low} <= 4'h1 << k;
         step(3);
         #1 chk({24'h0, general_diag}, 32'h0000_0001 << k);
         #1 chk({31'h0, irq}, 32'h0000_0001);
         rd(fsc_pkg::OFS_STATUS, 32'h0000_0001 << k);
         #1 chk({31'h0, irq}, 32'h0000_0000);
         {further_extra_load_supplies_low[5], first_extra_load_supply_low,
            main_load_supply_low, logic_sensor_supply_low} <= 4'h0;
         step(2);
      end
      wr(fsc_pkg::OFS_EVT_EN, 32'h0000_0000);
      further_extra_load_supplies_low[0] <= 1'b1;
      step(3);
      rd(fsc_pkg::OFS_STATUS, 32'h0000_0000);
      #1 chk({24'h0, general_diag}, 32'h0000_0008);
      $display("test supply events done");
      want_link <= 1'b0;
      {use_diag, wide} <= 2'h0;
      step(2);
      wr(fsc_pkg::OFS_CFG_LO, layout[31:0]);
      wr(fsc_pkg::OFS_CFG_HI, {24'h00_0000, layout[39:32]});
      logic_sensor_supply_on <= 1'b0;
      step(2);
      {logic_sensor_supply_on, want_link} <= 2'h3;
      step(4);
      #1 chk({31'h0, cyclic_connected}, 32'h0000_0001);
      wr(fsc_pkg::OFS_VALVE, 32'hFFFF_FFFF);
      step(2);
      #1 chk(valve_out, 32'h0000_FFFF);
      rd(fsc_pkg::OFS_LIVE, 32'h0000_0801);
      $display("test narrow valves done");
      stop_test();
   end
endmodule
bind fsc_slot_failsafe fsc_slot_failsafe_props #(.N_FURTHER(N_FURTHER),
   .VALVES(VALVES)) props (.sys_clk, .rst, .reg_wr, .logic_sensor_supply_on,
   .logic_sensor_supply_low, .main_load_supply_low,
   .first_extra_load_supply_low, .further_extra_load_supplies_low,
   .link_up, .bus_fault, .cyclic_connected, .valve_out, .general_diag, .irq);
